/* hw/dcpwm_pkg.sv */
// Package with register map, field positions and reset values of the dual PWM block.
package dcpwm_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DUTY_W = 10;
   localparam int unsigned CH_NUM = 2;
   // Register byte addresses.
   localparam logic [7:0] OFF_PERIOD_LIMIT = 8'h00;
   localparam logic [7:0] OFF_TIMER_CONTROL = 8'h04;
   localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
   localparam logic [7:0] OFF_CH0_CONTROL = 8'h10;
   localparam logic [7:0] OFF_CH0_DUTY_HIGH = 8'h14;
   localparam logic [7:0] OFF_CH0_DUTY_LOW = 8'h18;
   localparam logic [7:0] OFF_CH1_CONTROL = 8'h20;
   localparam logic [7:0] OFF_CH1_DUTY_HIGH = 8'h24;
   localparam logic [7:0] OFF_CH1_DUTY_LOW = 8'h28;
   // Channel control fields.
   localparam int unsigned CTL_RUN_BIT = 7;
   localparam int unsigned CTL_DRIVE_BIT = 6;
   localparam int unsigned CTL_LIVE_BIT = 5;
   localparam int unsigned CTL_POL_BIT = 4;
   // Duty low pair field and timer control field.
   localparam int unsigned DL_MSB = 7;
   localparam int unsigned DL_LSB = 6;
   localparam int unsigned TCTL_RUN_BIT = 0;
   // Reset values.
   localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [1:0] SUB_RST = 2'h0;
   localparam logic [1:0] SUB_LAST = 2'h3;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

/* hw/dcpwm_chan_if.sv */
// Interface carrying one PWM channel's settings, time base and results.
`timescale 1ns/1ps
interface dcpwm_chan_if;
   logic run;
   logic drive;
   logic pol;
   logic [9:0] duty;
   logic wrap;
   logic [9:0] tb_nxt;
   logic port_latch;
   logic live;
   logic pin;
   logic pin_oe;
   modport top (output run, drive, pol, duty, wrap, tb_nxt, port_latch,
                input live, pin, pin_oe);
   modport chan (input run, drive, pol, duty, wrap, tb_nxt, port_latch,
                 output live, pin, pin_oe);
endinterface

/* hw/dcpwm_channel.sv */
// One PWM channel: compare buffer, waveform and pin multiplexer.
`timescale 1ns/1ps
module dcpwm_channel
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   dcpwm_chan_if.chan ch
);
   logic [dcpwm_pkg::DUTY_W-1:0] buf_r;
   logic [dcpwm_pkg::DUTY_W-1:0] buf_nxt;
   logic wave_r;
   logic wave_nxt;
   logic pin_r;
   logic pin_nxt;
   logic oe_r;
   logic oe_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Waveform: set at the timer clear, dropped when the time base meets the duty.
   // Comparing against the next time base keeps the pulse width exact to a cycle.
   always_comb
   begin
      buf_nxt = buf_r;
      wave_nxt = wave_r;
      if (ch.wrap)
      begin
         buf_nxt = ch.duty; // [RULE9]
      end
      if (!ch.run)
      begin
         wave_nxt = 1'b0; // [RULE12]
      end
      else if (ch.wrap)
      begin
         wave_nxt = (ch.duty != dcpwm_pkg::DUTY_ZERO); // [RULE8]
      end
      else if (ch.tb_nxt == buf_r)
      begin
         wave_nxt = 1'b0; // [RULE8]
      end
      pin_nxt = ch.drive ? (wave_nxt ^ ch.pol) : ch.port_latch; // [RULE10] [RULE11]
      oe_nxt = ch.drive; // [RULE11]
   end

   // The compare buffer keeps its contents over reset, as the duty registers do.
   always_ff @(posedge clock_i)
   begin
      buf_r <= buf_nxt;
   end

   // Waveform and pin state.
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         wave_r <= 1'b0;
         pin_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         wave_r <= wave_nxt;
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign ch.live = wave_r ^ ch.pol; // [RULE12]
   assign ch.pin = pin_r;
   assign ch.pin_oe = oe_r;
endmodule

/* hw/dcpwm_top.sv */
// Dual-channel PWM register block with shared period timer and APB slave.
// Behaviour
// RULE1 - Duty high byte register holds the eight upper duty bits in bits 7..0.
// RULE2 - Duty low register bits 7..6 hold the two lowest duty bits.
// RULE3 - Duty low bits 5..0 read zero and ignore writes.
// RULE4 - Control register low nibble reads zero; upper nibble holds the functions.
// RULE5 - All implemented control bits reset to zero on every reset.
// RULE6 - Duty registers are undefined at power-up and keep contents over other resets.
// RULE7 - One shared period limit sets both periods; controls and duties are per channel.
// RULE8 - Output sets at timer clear, clears at duty match; large duty stays active.
// RULE9 - Duty values load into compare buffers only when timer matches period limit.
// RULE10 - Polarity invert bit makes the channel output active low.
// RULE11 - With pin drive disabled, the pin shows the ordinary port latch.
// RULE12 - Live level bit shows waveform; waveform runs only while module enabled.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module dcpwm_top
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [1:0] port_latch_i,
   output logic [1:0] pwm_pin_o,
   output logic [1:0] pwm_pin_oe_o
);
   localparam int unsigned N = dcpwm_pkg::CH_NUM;

   // Register state.
   logic [7:0] period_limit_r;
   logic [7:0] period_limit_nxt;
   logic timer_run_r;
   logic timer_run_nxt;
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic [1:0] sub_r;
   logic [1:0] sub_nxt;
   logic wrap;
   logic [2:0] ctl_r [N];
   logic [2:0] ctl_nxt [N];
   logic [7:0] dh_r [N];
   logic [7:0] dh_nxt [N];
   logic [1:0] dl_r [N];
   logic [1:0] dl_nxt [N];
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic access;
   logic wr_en;
   logic [31:0] rd_word;
   logic hit;
   logic live [N];
   logic [1:0] pin_w;
   logic [1:0] oe_w;

   ////////////////////////////////////////////////////////////////////////////
   // Shared time base: 8-bit count with two sub-cycle bits forms ten bits.
   // The prescaler is fixed at 1:1, so the sub bits advance every clock while the timer run bit is set.
   always_comb
   begin
      count_nxt = count_r;
      sub_nxt = sub_r;
      wrap = 1'b0;
      if (timer_run_r)
      begin
         sub_nxt = sub_r + 2'h1;
         if (sub_r == dcpwm_pkg::SUB_LAST)
         begin
            if (count_r == period_limit_r) // [RULE7]
            begin
               count_nxt = dcpwm_pkg::COUNT_RST;
               wrap = 1'b1; // [RULE9]
            end
            else
            begin
               count_nxt = count_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         count_r <= dcpwm_pkg::COUNT_RST;
         sub_r <= dcpwm_pkg::SUB_RST;
      end
      else
      begin
         count_r <= count_nxt;
         sub_r <= sub_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so pready rises in the second access cycle.
   // The registered answer keeps every bus output straight from a flip-flop.
   assign access = psel_i && penable_i && !pready_r;
   assign wr_en = psel_i && penable_i && pready_r && pwrite_i;

   // Read multiplexer and address decode.
   always_comb
   begin
      rd_word = 32'h0000_0000;
      hit = 1'b1;
      if (paddr_i == dcpwm_pkg::OFF_PERIOD_LIMIT)
      begin
         rd_word[7:0] = period_limit_r;
      end
      else if (paddr_i == dcpwm_pkg::OFF_TIMER_CONTROL)
      begin
         rd_word[dcpwm_pkg::TCTL_RUN_BIT] = timer_run_r;
      end
      else if (paddr_i == dcpwm_pkg::OFF_TIMER_COUNT)
      begin
         rd_word[7:0] = count_r;
      end
      else if (paddr_i == dcpwm_pkg::OFF_CH0_CONTROL || paddr_i == dcpwm_pkg::OFF_CH1_CONTROL)
      begin
         // Low nibble stays zero. [RULE4]
         rd_word[dcpwm_pkg::CTL_RUN_BIT] = ctl_r[paddr_i[5]][2];
         rd_word[dcpwm_pkg::CTL_DRIVE_BIT] = ctl_r[paddr_i[5]][1];
         rd_word[dcpwm_pkg::CTL_LIVE_BIT] = live[paddr_i[5]]; // [RULE12]
         rd_word[dcpwm_pkg::CTL_POL_BIT] = ctl_r[paddr_i[5]][0];
      end
      else if (paddr_i == dcpwm_pkg::OFF_CH0_DUTY_HIGH
               || paddr_i == dcpwm_pkg::OFF_CH1_DUTY_HIGH)
      begin
         rd_word[7:0] = dh_r[paddr_i[5]]; // [RULE1]
      end
      else if (paddr_i == dcpwm_pkg::OFF_CH0_DUTY_LOW
               || paddr_i == dcpwm_pkg::OFF_CH1_DUTY_LOW)
      begin
         rd_word[dcpwm_pkg::DL_MSB:dcpwm_pkg::DL_LSB] = dl_r[paddr_i[5]]; // [RULE2] [RULE3]
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // Bus answer and register writes; a write lands on the edge that sees pready.
   always_comb
   begin
      pready_nxt = access;
      pslverr_nxt = access && !hit;
      prdata_nxt = prdata_r;
      if (access && !pwrite_i)
      begin
         prdata_nxt = rd_word;
      end
      period_limit_nxt = period_limit_r;
      timer_run_nxt = timer_run_r;
      ctl_nxt = ctl_r;
      dh_nxt = dh_r;
      dl_nxt = dl_r;
      if (wr_en)
      begin
         if (paddr_i == dcpwm_pkg::OFF_PERIOD_LIMIT)
         begin
            period_limit_nxt = pwdata_i[7:0]; // [RULE7]
         end
         else if (paddr_i == dcpwm_pkg::OFF_TIMER_CONTROL)
         begin
            timer_run_nxt = pwdata_i[dcpwm_pkg::TCTL_RUN_BIT];
         end
         else if (paddr_i == dcpwm_pkg::OFF_CH0_CONTROL
                  || paddr_i == dcpwm_pkg::OFF_CH1_CONTROL)
         begin
            // The live level bit is read only and the low nibble is dropped. [RULE4]
            ctl_nxt[paddr_i[5]] = {pwdata_i[dcpwm_pkg::CTL_RUN_BIT],
                                   pwdata_i[dcpwm_pkg::CTL_DRIVE_BIT],
                                   pwdata_i[dcpwm_pkg::CTL_POL_BIT]};
         end
         else if (paddr_i == dcpwm_pkg::OFF_CH0_DUTY_HIGH
                  || paddr_i == dcpwm_pkg::OFF_CH1_DUTY_HIGH)
         begin
            dh_nxt[paddr_i[5]] = pwdata_i[7:0]; // [RULE1]
         end
         else if (paddr_i == dcpwm_pkg::OFF_CH0_DUTY_LOW
                  || paddr_i == dcpwm_pkg::OFF_CH1_DUTY_LOW)
         begin
            dl_nxt[paddr_i[5]] = pwdata_i[dcpwm_pkg::DL_MSB:dcpwm_pkg::DL_LSB]; // [RULE2] [RULE3]
         end
      end
   end

   // Control and bus state reset on every reset: the period limit to FF, everything else to zero.
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         period_limit_r <= dcpwm_pkg::PERIOD_LIMIT_RST;
         timer_run_r <= 1'b0;
         for (int i = 0; i < N; i++)
         begin
            ctl_r[i] <= 3'h0; // [RULE5]
         end
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= dcpwm_pkg::RDATA_RST;
      end
      else
      begin
         period_limit_r <= period_limit_nxt;
         timer_run_r <= timer_run_nxt;
         ctl_r <= ctl_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Duty registers carry no reset: unknown at power-up, kept across resets.
   always_ff @(posedge clock_i)
   begin
      dh_r <= dh_nxt; // [RULE6]
      dl_r <= dl_nxt; // [RULE6]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channels share the time base and wrap; each has its own settings.
   for (genvar g = 0; g < N; g++)
   begin : g_ch
      dcpwm_chan_if chif ();
      assign chif.run = ctl_r[g][2];
      assign chif.drive = ctl_r[g][1];
      assign chif.pol = ctl_r[g][0];
      assign chif.duty = {dh_r[g], dl_r[g]};
      assign chif.wrap = wrap; // [RULE7]
      assign chif.tb_nxt = {count_nxt, sub_nxt};
      assign chif.port_latch = port_latch_i[g];
      assign live[g] = chif.live;
      assign pin_w[g] = chif.pin;
      assign oe_w[g] = chif.pin_oe;
      dcpwm_channel u_ch
      (
         .clock_i(clock_i),
         .rst_n_i(rst_n_i),
         .ch(chif)
      );
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign pwm_pin_o = pin_w;
   assign pwm_pin_oe_o = oe_w;
endmodule

/* sim/dcpwm_top_asserts.sv */
// Port checker for the dual PWM register block.
`timescale 1ns/1ps
module dcpwm_top_asserts
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [1:0] port_latch_i,
   input wire logic [1:0] pwm_pin_o,
   input wire logic [1:0] pwm_pin_oe_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   //////////////////////////////////////////////////
   // An APB access is a setup cycle and then an access cycle.
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      s_setup ##1 (psel_i && penable_i);
   endsequence
   // The read that completes in this cycle.
   sequence s_rd_done;
      pready_o && !pwrite_i;
   endsequence
   apb_wait_state_a: assert property (s_access |=> pready_o)
      else $error("ready missing after one wait state");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
      else $error("ready without an access");
   err_read_a: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
      else $error("refused read not zero");
   ctl_nibble_a: assert property (
      s_rd_done ##0 (paddr_i == 8'h10 || paddr_i == 8'h20) |-> prdata_o[3:0] == 4'h0)
      else $error("control low nibble not zero");
   low_unused_a: assert property (
      s_rd_done ##0 (paddr_i == 8'h18 || paddr_i == 8'h28) |-> prdata_o[5:0] == 6'h00)
      else $error("duty low unused bits not zero");
   // The pin falls back to the latch a cycle late, so the first cycle after reset is skipped.
   pin_latch_a: assert property ($past(rst_n_i) |->
      (pwm_pin_o & ~pwm_pin_oe_o) == ($past(port_latch_i) & ~pwm_pin_oe_o))
      else $error("undriven pin not following latch");
   reset_clear_a: assert property (disable iff (1'b0)
      !rst_n_i |=> pwm_pin_oe_o == 2'b00 && !pready_o && !pslverr_o)
      else $error("outputs not cleared by reset");
endmodule
bind dcpwm_top dcpwm_top_asserts u_dcpwm_top_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .port_latch_i(port_latch_i), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o));

/* sim/dcpwm_top_tb.sv */
// Self-checking testbench for the dual PWM register block.
`timescale 1ns/1ps
module dcpwm_top_tb;
   localparam int PL = 3;
   localparam int PER = 4 * (PL + 1);
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [1:0] latch = 2'h0;
   logic [31:0] prdata;
   logic pready;
   logic perr;
   logic [1:0] pin;
   logic [1:0] oe;
   logic [7:0] b;
   logic [32:0] q[$];
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 89889;
   int h0;
   int h1;
   int d;
   dcpwm_top u_dcpwm_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(perr), .port_latch_i(latch), .pwm_pin_o(pin),
      .pwm_pin_oe_o(oe));
   //////////////////////////////////////////////////
   // Free-running 250 MHz clock.
   initial
   begin
      forever #2 clock_i = ~clock_i;
   end
   task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; the request is held until ready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= v;
      @(posedge clock_i);
      pen <= 1'b1;
      // Wait as long as the slave needs; only the watchdog ends a hang.
      do
      begin
         @(posedge clock_i);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic duty(input logic [7:0] c, input int v);
      wr(c + 8'h04, v >> 2);
      wr(c + 8'h08, (v & 3) << 6);
   endtask
   // Counts high pin cycles over one full period, whatever its phase.
   task automatic win(output int a, output int z);
      a = 0;
      z = 0;
      repeat (PER)
      begin
         @(posedge clock_i);
         a += (pin[0] === 1'b1);
         z += (pin[1] === 1'b1);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Read answers are matched in order against the noted expectations.
   always @(posedge clock_i)
      if (pready === 1'b1 && !pwr && q.size() > 0)
         chk("read", {perr, prdata}, q.pop_front());
   // A hang counts as a failure.
   initial
   begin
      #100000;
      n_mismatch++;
      end_sim();
   end
   //////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(dcpwm_pkg::OFF_CH0_CONTROL, 33'h0);
      rd(dcpwm_pkg::OFF_CH1_CONTROL, 33'h0);
      rd(dcpwm_pkg::OFF_PERIOD_LIMIT, {25'h0, dcpwm_pkg::PERIOD_LIMIT_RST});
      rd(8'hFC, 33'h1_0000_0000);
      $display("test reset done");
      for (int c = 0; c < 2; c++)
      begin
         b = c ? dcpwm_pkg::OFF_CH1_CONTROL : dcpwm_pkg::OFF_CH0_CONTROL;
         d = $random(seed);
         wr(b + 8'h04, d);
         wr(b + 8'h08, d);
         rd(b + 8'h04, {25'h0, d[7:0]});
         rd(b + 8'h08, {25'h0, d[7:6], 6'h00});
         wr(b, 32'hFFFF_FF5F);
         rd(b, {25'h0, 8'h70});
         chk("pin", pin[c], 33'h1);
         chk("oe", oe[c], 33'h1);
      end
      $display("test regs done");
      wr(dcpwm_pkg::OFF_PERIOD_LIMIT, PL);
      wr(dcpwm_pkg::OFF_CH1_CONTROL, 32'hD0);
      duty(dcpwm_pkg::OFF_CH1_CONTROL, 1023);
      wr(dcpwm_pkg::OFF_CH0_CONTROL, 32'hC0);
      wr(dcpwm_pkg::OFF_TIMER_CONTROL, 32'h1);
      rd(dcpwm_pkg::OFF_TIMER_CONTROL, 33'h1);
      for (int i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 0 : (i == 3) ? PER : 1 + $unsigned($random(seed)) % (PER - 1);
         duty(dcpwm_pkg::OFF_CH0_CONTROL, d);
         repeat (3 * PER) @(posedge clock_i);
         win(h0, h1);
         chk("high0", h0, d);
         chk("high1", h1, 0);
      end
      $display("test wave done");
      wr(dcpwm_pkg::OFF_CH0_CONTROL, 32'h80);
      repeat (8)
      begin
         latch <= $random(seed);
         @(posedge clock_i);
      end
      @(posedge clock_i);
      chk("latch", pin[0], latch[0]);
      wr(dcpwm_pkg::OFF_CH0_CONTROL, 32'h40);
      win(h0, h1);
      chk("stopped", h0, 0);
      $display("test pin done");
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk("oe", oe, 33'h0);
      rst_n_i <= 1'b1;
      rd(dcpwm_pkg::OFF_CH0_CONTROL, 33'h0);
      rd(dcpwm_pkg::OFF_CH0_DUTY_HIGH, 33'(PER >> 2));
      rd(dcpwm_pkg::OFF_CH0_DUTY_LOW, 33'h0);
      repeat (4) @(posedge clock_i);
      $display("test rereset done");
      end_sim();
   end
endmodule
